/* core/pmx_cfg_if.sv */
/*
  Interface carrying the decoded configuration from the register file to the
  pad multiplexer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface pmx_cfg_if;
  pmx_pkg::pmx_spi_fn_t spi_fn;          // Shared pin function.
  logic uart1_counter_pin_select;        // 1 gives counter the serial1 pins.
  logic [1:0] timer_pin_select;          // Per timer, 1 gives pins to counter.
  logic serial_port_drive_strength;      // Serial port group strength.
  logic counter_array_drive_strength;    // Counter group strength.
  modport regs (output spi_fn, uart1_counter_pin_select, timer_pin_select,
                serial_port_drive_strength, counter_array_drive_strength);
  modport mux (input spi_fn, uart1_counter_pin_select, timer_pin_select,
               serial_port_drive_strength, counter_array_drive_strength);
endinterface : pmx_cfg_if

/* core/pmx_map.svh */
/*
  Register indices, field positions, reset values and idle levels of the pad
  direction and pin sharing block, as macros.
  Assumes it is included by bare name from every design file that needs it.
*/
// Operation
// - Clock pad drives in master, inputs in slave.
// - MISO pad receives in master, sends in slave.
// - Slave MISO tri-stated when not transmitting.
// - MOSI pad sends in master, receives in slave.
// - Master MOSI driven through a tri-state driver.
// - Single-wire data pad is open-drain only.
// - Active-low strong pull-up control output provided.
// - Byte 3 shares slave selects, single-wire, CAN.
// - Counter clock shares pin with serial1 receive.
// - Five counter pins share timer and transmit.
// - Ethernet positive pin swaps role in crossover.
// - Byte 4 selects two group drive strengths.
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
// Register indices; the byte address is four times the index.
`define PMX_IDX_PIN_SEL 3'h3
`define PMX_IDX_DRIVE 3'h4
`define PMX_IDX_STATUS 3'h5
// Reset values of the configuration bytes.
`define PMX_PIN_SEL_RST 8'h00
`define PMX_DRIVE_RST 8'h00
// Field positions inside the pin select byte.
`define PMX_SPI_SEL_MSB 1
`define PMX_SPI_SEL_LSB 0
`define PMX_UART1_SEL_BIT 2
`define PMX_TIMER_SEL_MSB 4
`define PMX_TIMER_SEL_LSB 3
// Field positions inside the drive strength byte.
`define PMX_SERIAL_PORT_DRIVE_STRENGTH_BIT 0
`define PMX_COUNTER_ARRAY_DRIVE_STRENGTH_BIT 1
// Width of the synchronised pad input vector and of the status word.
`define PMX_SYNC_W 11
`define PMX_STATUS_W 13
// Levels shown to a peripheral whose pin is given to another function.
`define PMX_IDLE_HIGH 1'b1
`define PMX_IDLE_LOW 1'b0
`define PMX_IDLE_CEX 5'h00
`endif

/* core/pmx_pad_mux.sv */
/*
  Pad direction and pin sharing for the serial port, single-wire bus, CAN,
  counter array, timers, serial port 1 and the Ethernet positive receive pin.
  Assumes pad inputs are asynchronous and pass a two-flop synchroniser, and
  that peripheral-side inputs and mode levels come from the same clock.
*/
`timescale 1ns/1ns
`include "pmx_map.svh"
module pmx_pad_mux (
  input wire logic i_clock,
  input wire logic i_rst,
  // Register bus.
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire pmx_pkg::pmx_word_t i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output pmx_pkg::pmx_word_t o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial port core side.
  input wire logic i_spi_master,
  input wire logic i_spi_sclk_out,
  input wire logic i_spi_mosi_out,
  input wire logic i_spi_mosi_oe,
  input wire logic i_spi_miso_out,
  input wire logic i_spi_miso_oe,
  input wire logic [2:1] i_spi_select_n,
  output logic o_spi_sclk_in,
  output logic o_spi_miso_in,
  output logic o_spi_mosi_in,
  // Single-wire bus and CAN core side.
  input wire logic i_sw_pull_low,
  input wire logic i_strong_pullup_enable_n,
  output logic o_sw_data_in,
  input wire logic i_can_transmit,
  output logic o_can_receive,
  // Counter array, timers and serial port 1 core side.
  input wire logic [4:0] i_counter_module_out,
  input wire logic [4:0] i_counter_module_oe,
  output logic [4:0] o_counter_module_in,
  output logic o_counter_array_ext_clock,
  output logic o_serial1_receive,
  input wire logic i_serial1_transmit,
  output logic o_timer1_gate,
  output logic o_timer1_clock,
  output logic o_timer2_gate,
  output logic o_timer2_clock,
  // Ethernet side.
  input wire logic i_eth_mdix,
  input wire logic i_eth_tx_pos,
  output logic o_eth_rx_pos,
  // Pads.
  input wire logic i_sclk_pad_in,
  output logic o_sclk_pad_out,
  output logic o_sclk_pad_oe,
  input wire logic i_miso_pad_in,
  output logic o_miso_pad_out,
  output logic o_miso_pad_oe,
  input wire logic i_mosi_pad_in,
  output logic o_mosi_pad_out,
  output logic o_mosi_pad_oe,
  input wire logic i_shared_a_pad_in,
  output logic o_shared_a_pad_out,
  output logic o_shared_a_pad_oe,
  output logic o_shared_b_pad_out,
  output logic o_shared_b_pad_oe,
  input wire logic i_ext_clock_pad_in,
  input wire logic [4:0] i_counter_module_pin_in,
  output logic [4:0] o_counter_module_pin_out,
  output logic [4:0] o_counter_module_pin_oe,
  input wire logic i_eth_rx_pos_pin_in,
  output logic o_eth_rx_pos_pin_out,
  output logic o_eth_rx_pos_pin_oe,
  // Pad drive strength controls.
  output logic o_serial_port_drive_strength,
  output logic o_counter_array_drive_strength
);
  import pmx_pkg::*;

  pmx_cfg_if cfg ();                // Decoded configuration.
  logic [`PMX_SYNC_W-1:0] pad_raw;  // Raw pad levels.
  logic [`PMX_SYNC_W-1:0] pad_s;    // Synchronised pad levels.
  logic s_sclk;                     // Synchronised clock pad.
  logic s_miso;                     // Synchronised MISO pad.
  logic s_mosi;                     // Synchronised MOSI pad.
  logic s_shared_a;                 // Synchronised shared pin A.
  logic s_eci;                      // Synchronised counter clock pin.
  logic [4:0] s_cex;                // Synchronised counter module pins.
  logic s_eth;                      // Synchronised Ethernet pin.
  logic [4:0] cex_own;              // Counter array owns these pins.

  assign pad_raw = {i_eth_rx_pos_pin_in, i_counter_module_pin_in, i_ext_clock_pad_in,
                    i_shared_a_pad_in, i_mosi_pad_in, i_miso_pad_in, i_sclk_pad_in};
  assign {s_eth, s_cex, s_eci, s_shared_a, s_mosi, s_miso, s_sclk} = pad_s;
  assign cex_own = pmx_cex_owner(cfg.uart1_counter_pin_select, cfg.timer_pin_select);

  // Pad levels cross in through two flops before any mux reads them.
  pmx_sync #(
    .W(`PMX_SYNC_W)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(pad_raw),
    .o_sync(pad_s)
  );

  // Register file; status shows the mode inputs and the pad levels.
  pmx_regs u_regs (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .i_status({i_eth_mdix, i_spi_master, pad_s}),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .cfg(cfg)
  );

  // Serial port pads swap direction with master and slave mode.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_sclk_pad_out <= 1'b0;
      o_sclk_pad_oe <= 1'b0;
      o_miso_pad_out <= 1'b0;
      o_miso_pad_oe <= 1'b0;
      o_mosi_pad_out <= 1'b0;
      o_mosi_pad_oe <= 1'b0;
      o_spi_sclk_in <= `PMX_IDLE_LOW;
      o_spi_miso_in <= `PMX_IDLE_LOW;
      o_spi_mosi_in <= `PMX_IDLE_LOW;
    end else begin
      o_sclk_pad_out <= i_spi_sclk_out;
      o_sclk_pad_oe <= i_spi_master;
      o_spi_sclk_in <= i_spi_master ? `PMX_IDLE_LOW : s_sclk;
      o_miso_pad_out <= i_spi_miso_out;
      o_miso_pad_oe <= ~i_spi_master & i_spi_miso_oe;
      o_spi_miso_in <= i_spi_master ? s_miso : `PMX_IDLE_LOW;
      o_mosi_pad_out <= i_spi_mosi_out;
      o_mosi_pad_oe <= i_spi_master & i_spi_mosi_oe;
      o_spi_mosi_in <= i_spi_master ? `PMX_IDLE_LOW : s_mosi;
    end
  end

  // Shared pins A and B; an unused function sees idle and drives nothing.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_shared_a_pad_out <= 1'b0;
      o_shared_a_pad_oe <= 1'b0;
      o_shared_b_pad_out <= 1'b0;
      o_shared_b_pad_oe <= 1'b0;
      o_sw_data_in <= `PMX_IDLE_HIGH;
      o_can_receive <= `PMX_IDLE_HIGH;
    end else begin
      o_sw_data_in <= `PMX_IDLE_HIGH;
      o_can_receive <= `PMX_IDLE_HIGH;
      case (cfg.spi_fn)
        PMX_FN_SELECT: begin
          // Slave selects only drive in master mode.
          o_shared_a_pad_out <= i_spi_select_n[1];
          o_shared_a_pad_oe <= i_spi_master;
          o_shared_b_pad_out <= i_spi_select_n[2];
          o_shared_b_pad_oe <= i_spi_master;
        end
        PMX_FN_SINGLE_WIRE: begin
          // Open drain: only ever a driven low, never a driven high.
          o_shared_a_pad_out <= 1'b0;
          o_shared_a_pad_oe <= i_sw_pull_low;
          o_sw_data_in <= s_shared_a;
          o_shared_b_pad_out <= i_strong_pullup_enable_n;
          o_shared_b_pad_oe <= 1'b1;
        end
        PMX_FN_CAN: begin
          o_shared_a_pad_out <= 1'b0;
          o_shared_a_pad_oe <= 1'b0;
          o_can_receive <= s_shared_a;
          o_shared_b_pad_out <= i_can_transmit;
          o_shared_b_pad_oe <= 1'b1;
        end
        default: begin
          // Unassigned code parks both pins released.
          o_shared_a_pad_out <= 1'b0;
          o_shared_a_pad_oe <= 1'b0;
          o_shared_b_pad_out <= 1'b0;
          o_shared_b_pad_oe <= 1'b0;
        end
      endcase
    end
  end

  // Counter clock pin and serial1 receive share one input.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_counter_array_ext_clock <= `PMX_IDLE_LOW;
      o_serial1_receive <= `PMX_IDLE_HIGH;
    end else begin
      o_counter_array_ext_clock <= cfg.uart1_counter_pin_select ? s_eci : `PMX_IDLE_LOW;
      o_serial1_receive <= cfg.uart1_counter_pin_select ? `PMX_IDLE_HIGH : s_eci;
    end
  end

  // Counter module pins; pin 0 else transmits serial1, 1..4 feed timers.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_counter_module_pin_out <= 5'h00;
      o_counter_module_pin_oe <= 5'h00;
      o_counter_module_in <= `PMX_IDLE_CEX;
      o_timer1_clock <= `PMX_IDLE_LOW;
      o_timer1_gate <= `PMX_IDLE_LOW;
      o_timer2_clock <= `PMX_IDLE_LOW;
      o_timer2_gate <= `PMX_IDLE_LOW;
    end else begin
      o_counter_module_pin_out <= cex_own & i_counter_module_out |
                                  {4'h0, ~cex_own[0] & i_serial1_transmit};
      o_counter_module_pin_oe <= cex_own & i_counter_module_oe | {4'h0, ~cex_own[0]};
      o_counter_module_in <= cex_own & s_cex;
      o_timer1_clock <= ~cex_own[1] & s_cex[1];
      o_timer1_gate <= ~cex_own[2] & s_cex[2];
      o_timer2_clock <= ~cex_own[3] & s_cex[3];
      o_timer2_gate <= ~cex_own[4] & s_cex[4];
    end
  end

  // Ethernet positive pin receives in straight mode, transmits in crossover.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_eth_rx_pos_pin_out <= 1'b0;
      o_eth_rx_pos_pin_oe <= 1'b0;
      o_eth_rx_pos <= `PMX_IDLE_LOW;
    end else begin
      o_eth_rx_pos_pin_out <= i_eth_tx_pos;
      o_eth_rx_pos_pin_oe <= i_eth_mdix;
      o_eth_rx_pos <= i_eth_mdix ? `PMX_IDLE_LOW : s_eth;
    end
  end

  // Drive strengths follow the configuration byte one cycle later.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_serial_port_drive_strength <= 1'b0;
      o_counter_array_drive_strength <= 1'b0;
    end else begin
      o_serial_port_drive_strength <= cfg.serial_port_drive_strength;
      o_counter_array_drive_strength <= cfg.counter_array_drive_strength;
    end
  end

  // Clock pad drive follows the mode; in slave the pad level reaches the core.
  // Three edges after reset are skipped, since the synchroniser still holds zeros.
  property p_sclk_dir;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst, 3) |-> o_sclk_pad_oe == $past(i_spi_master) &&
             ($past(i_spi_master) || o_spi_sclk_in == $past(i_sclk_pad_in, 3));
  endproperty
  a_sclk_dir: assert property (p_sclk_dir) else $error("clock pad direction wrong");

  // In master mode the MISO pad reaches the core three cycles later.
  property p_miso_rx;
    @(posedge i_clock) disable iff (i_rst)
    $past(i_spi_master) |-> o_spi_miso_in == $past(i_miso_pad_in, 3) && !o_miso_pad_oe;
  endproperty
  a_miso_rx: assert property (p_miso_rx) else $error("miso receive path wrong");

  // Slave MISO driver only on while transmitting.
  property p_miso_tri;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_spi_master) |-> o_miso_pad_oe == $past(i_spi_miso_oe);
  endproperty
  a_miso_tri: assert property (p_miso_tri) else $error("miso driver not released");

  // In slave mode the MOSI pad reaches the core and is never driven.
  property p_mosi_rx;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_spi_master) && !$past(i_rst, 3) |->
      o_spi_mosi_in == $past(i_mosi_pad_in, 3) && !o_mosi_pad_oe;
  endproperty
  a_mosi_rx: assert property (p_mosi_rx) else $error("mosi receive path wrong");

  // Master MOSI driver follows the core enable.
  property p_mosi_tri;
    @(posedge i_clock) disable iff (i_rst)
    $past(i_spi_master) |-> o_mosi_pad_oe == $past(i_spi_mosi_oe) &&
                            o_mosi_pad_out == $past(i_spi_mosi_out);
  endproperty
  a_mosi_tri: assert property (p_mosi_tri) else $error("mosi driver wrong");

  // Single-wire pin never drives high.
  property p_open_drain;
    @(posedge i_clock) disable iff (i_rst)
    $past(cfg.spi_fn == PMX_FN_SINGLE_WIRE) |->
      !o_shared_a_pad_out && o_shared_a_pad_oe == $past(i_sw_pull_low);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("single-wire pin drove high");

  // Strong pull-up pin carries the active-low control.
  property p_pullup;
    @(posedge i_clock) disable iff (i_rst)
    $past(cfg.spi_fn == PMX_FN_SINGLE_WIRE) |->
      o_shared_b_pad_oe && o_shared_b_pad_out == $past(i_strong_pullup_enable_n);
  endproperty
  a_pullup: assert property (p_pullup) else $error("strong pull-up level wrong");

  // CAN receive follows pin A, else rests recessive.
  property p_can;
    @(posedge i_clock) disable iff (i_rst)
    o_can_receive == ($past(cfg.spi_fn == PMX_FN_CAN) ? $past(i_shared_a_pad_in, 3) : 1'b1);
  endproperty
  a_can: assert property (p_can) else $error("CAN receive path wrong");

  // With the counter selected, serial1 receive rests idle and the counter clock sees the pin.
  property p_eci;
    @(posedge i_clock) disable iff (i_rst)
    $past(cfg.uart1_counter_pin_select) |->
      o_serial1_receive && o_counter_array_ext_clock == $past(i_ext_clock_pad_in, 3);
  endproperty
  a_eci: assert property (p_eci) else $error("counter clock path wrong");

  // Pin 0 carries serial1 transmit when not owned by the counter array.
  property p_cex0;
    @(posedge i_clock) disable iff (i_rst)
    !$past(cfg.uart1_counter_pin_select) && !$past(i_rst, 3) |->
      o_counter_module_pin_oe[0] && o_counter_module_pin_out[0] == $past(i_serial1_transmit);
  endproperty
  a_cex0: assert property (p_cex0) else $error("serial1 transmit pin wrong");

  // Timer 2 pins 3 and 4, when timer-owned, are never driven and the counter sees idle there.
  property p_timer_pins;
    @(posedge i_clock) disable iff (i_rst)
    !$past(cfg.timer_pin_select[1]) |->
      o_counter_module_pin_oe[4:3] == 2'h0 && o_counter_module_in[4:3] == 2'h0;
  endproperty
  a_timer_pins: assert property (p_timer_pins) else $error("timer pin driven");

  // Crossover turns the receive pin into a driven transmit pin.
  property p_eth;
    @(posedge i_clock) disable iff (i_rst)
    $past(i_eth_mdix) |-> o_eth_rx_pos_pin_oe && o_eth_rx_pos_pin_out == $past(i_eth_tx_pos);
  endproperty
  a_eth: assert property (p_eth) else $error("crossover pin role wrong");

  // Counter array strength output tracks the configuration byte.
  property p_ods;
    @(posedge i_clock) disable iff (i_rst)
    o_counter_array_drive_strength == $past(cfg.counter_array_drive_strength);
  endproperty
  a_ods: assert property (p_ods) else $error("drive strength wrong");
endmodule : pmx_pad_mux

/* core/pmx_pkg.sv */
/*
  Types and one shared decode function of the pad direction block.
  Assumes nothing of its surroundings.
*/
package pmx_pkg;
  // Function given to the two pins shared by slave selects, single-wire and CAN.
  typedef enum logic [1:0] {
    PMX_FN_SELECT,
    PMX_FN_SINGLE_WIRE,
    PMX_FN_CAN,
    PMX_FN_NONE
  } pmx_spi_fn_t;
  typedef logic [7:0] pmx_byte_t;   // One configuration byte.
  typedef logic [31:0] pmx_word_t;  // One bus word.

  // Counter array owns a module pin when its select bit is set.
  function automatic logic [4:0] pmx_cex_owner(input logic uart_sel, input logic [1:0] tsel);
    return {tsel[1], tsel[1], tsel[0], tsel[0], uart_sel};
  endfunction : pmx_cex_owner
endpackage : pmx_pkg

/* core/pmx_regs.sv */
/*
  Avalon-MM slave holding the pin select byte, the drive strength byte and a
  read-only status word of the two mode inputs and the synchronised pad levels.
  Assumes a master that holds its request until waitrequest is seen low.
*/
`timescale 1ns/1ns
`include "pmx_map.svh"
module pmx_regs (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire pmx_pkg::pmx_word_t i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [`PMX_STATUS_W-1:0] i_status,
  output pmx_pkg::pmx_word_t o_avs_readdata,
  output logic o_avs_waitrequest,
  pmx_cfg_if.regs cfg
);
  import pmx_pkg::*;

  pmx_byte_t pin_sel_q;  // Pin select byte.
  pmx_byte_t drive_q;    // Drive strength byte.
  pmx_word_t rdata_q;    // Registered read data.
  logic wait_q;          // Waitrequest, high while idle.
  logic [2:0] idx;       // Word index of the access.
  logic req;             // Any request present.
  logic done;            // Request completes at this edge.

  assign idx = i_avs_address[4:2];
  assign req = i_avs_read | i_avs_write;
  assign done = req & ~wait_q;

  // Every access takes one wait cycle; the pause gives time to register data.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Read data are captured during the wait cycle; unmapped words read zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h00000000;
    end else if (i_avs_read && wait_q) begin
      case (idx)
        `PMX_IDX_PIN_SEL: rdata_q <= {24'h000000, pin_sel_q};
        `PMX_IDX_DRIVE: rdata_q <= {24'h000000, drive_q};
        `PMX_IDX_STATUS: rdata_q <= {19'h00000, i_status};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Writes land on the completing edge; only the low byte lane carries data.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_sel_q <= `PMX_PIN_SEL_RST;
      drive_q <= `PMX_DRIVE_RST;
    end else if (done && i_avs_write && i_avs_byteenable[0]) begin
      if (idx == `PMX_IDX_PIN_SEL) begin
        pin_sel_q <= i_avs_writedata[7:0];
      end
      if (idx == `PMX_IDX_DRIVE) begin
        drive_q <= i_avs_writedata[7:0];
      end
    end
  end

  assign cfg.spi_fn = pmx_spi_fn_t'(pin_sel_q[`PMX_SPI_SEL_MSB:`PMX_SPI_SEL_LSB]);
  assign cfg.uart1_counter_pin_select = pin_sel_q[`PMX_UART1_SEL_BIT];
  assign cfg.timer_pin_select = pin_sel_q[`PMX_TIMER_SEL_MSB:`PMX_TIMER_SEL_LSB];
  assign cfg.serial_port_drive_strength = drive_q[`PMX_SERIAL_PORT_DRIVE_STRENGTH_BIT];
  assign cfg.counter_array_drive_strength = drive_q[`PMX_COUNTER_ARRAY_DRIVE_STRENGTH_BIT];
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // A write of the pin select byte is visible on the next cycle.
  property p_sel_write;
    @(posedge i_clock) disable iff (i_rst)
    (done && i_avs_write && i_avs_byteenable[0] && idx == `PMX_IDX_PIN_SEL)
      |=> pin_sel_q == $past(i_avs_writedata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("pin select write lost");
endmodule : pmx_regs

/* core/pmx_sync.sv */
/*
  Two-flop synchroniser for a vector of pad inputs.
  Assumes every bit is an independent level; no bus coherence is promised.
*/
`timescale 1ns/1ns
module pmx_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;  // First stage, read only by the second stage.
  logic [W-1:0] sync_q;  // Second stage, safe for logic.

  // Both stages clear to zero; pads settle before anything trusts them.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : pmx_sync

/* verif/pmx_pad_mux_tb.sv */
/*
  Self-checking bench of the pad direction block, with a far-side pad model.
  Assumes the register slave answers within a few cycles.
*/
`timescale 1ns/1ns
module pmx_pad_mux_tb;
  import pmx_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [4:0] i_avs_address = 5'h00;
  logic [3:0] i_avs_byteenable = 4'hF;
  pmx_word_t i_avs_writedata = 32'h0, o_avs_readdata;
  logic o_avs_waitrequest, i_spi_master = 1'b0, i_spi_sclk_out = 1'b0, i_spi_mosi_out = 1'b0;
  logic i_spi_mosi_oe = 1'b0, i_spi_miso_out = 1'b0, i_spi_miso_oe = 1'b0, i_sw_pull_low = 1'b0;
  logic i_strong_pullup_enable_n = 1'b1, i_can_transmit = 1'b1, i_serial1_transmit = 1'b0;
  logic i_eth_mdix = 1'b0, i_eth_tx_pos = 1'b0, i_ext_clock_pad_in = 1'b0;
  logic i_eth_rx_pos_pin_in = 1'b0;
  logic [2:1] i_spi_select_n = 2'h3;
  logic [4:0] i_counter_module_out = 5'h00, i_counter_module_oe = 5'h00;
  logic [4:0] i_counter_module_pin_in = 5'h00;
  logic [4:0] o_counter_module_in, o_counter_module_pin_out, o_counter_module_pin_oe;
  logic [3:0] far_val = 4'h0, far_oe = 4'h0; // What the far devices drive.
  wire logic i_sclk_pad_in, i_miso_pad_in, i_mosi_pad_in, i_shared_a_pad_in;
  logic o_spi_sclk_in, o_spi_miso_in, o_spi_mosi_in, o_sw_data_in, o_can_receive, o_eth_rx_pos;
  logic o_counter_array_ext_clock, o_serial1_receive, o_timer1_gate, o_timer1_clock;
  logic o_timer2_gate, o_timer2_clock, o_sclk_pad_out, o_sclk_pad_oe, o_miso_pad_out;
  logic o_miso_pad_oe, o_mosi_pad_out, o_mosi_pad_oe, o_shared_a_pad_out, o_shared_a_pad_oe;
  logic o_shared_b_pad_out, o_shared_b_pad_oe, o_eth_rx_pos_pin_out, o_eth_rx_pos_pin_oe;
  logic o_serial_port_drive_strength, o_counter_array_drive_strength;
  // Expected shared pin state for each function code, held in a table.
  logic [4:0] fn_exp [4] = '{5'h1B, 5'h19, 5'h0E, 5'h03};
  int err_count = 0, samples_checked = 0;

  // Clock at 250 MHz.
  always #2 i_clock = ~i_clock;

  // Every bench signal carries its port's name, so all ports join by name.
  pmx_pad_mux i_dut (.*);

  pmx_pad_peer i_peer (
    .i_dut_out({o_shared_a_pad_out, o_mosi_pad_out, o_miso_pad_out, o_sclk_pad_out}),
    .i_dut_oe({o_shared_a_pad_oe, o_mosi_pad_oe, o_miso_pad_oe, o_sclk_pad_oe}),
    .i_far_val(far_val),
    .i_far_oe(far_oe),
    .o_pad({i_shared_a_pad_in, i_mosi_pad_in, i_miso_pad_in, i_sclk_pad_in})
  );

  // Compares with case equality, so an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc

  // One bus access; for a read, d is the expected data. The request is held
  // until waitrequest is sampled low, since the slave may stretch it.
  task automatic bus(input logic wr, input logic [4:0] a, input pmx_word_t d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (o_avs_waitrequest !== 1'b0) begin
      err_count++;
      conclude();
    end
    if (!wr) chk(o_avs_readdata, d);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    cyc(5);
    i_rst <= 1'b0;
    bus(0, 5'h0C, 32'h0);
    bus(0, 5'h00, 32'h0);
    bus(0, 5'h14, 32'hF);
    bus(1, 5'h10, 32'h1);
    cyc(3);
    chk({o_serial_port_drive_strength, o_counter_array_drive_strength}, 2'h2);
    bus(1, 5'h10, 32'h2);
    cyc(3);
    chk({o_serial_port_drive_strength, o_counter_array_drive_strength}, 2'h1);
    $display("test registers done");
    i_spi_master <= 1'b1;
    i_spi_sclk_out <= 1'b1;
    i_spi_mosi_out <= 1'b1;
    i_spi_mosi_oe <= 1'b1;
    cyc(5);
    chk({o_sclk_pad_oe, o_sclk_pad_out, o_mosi_pad_oe, o_mosi_pad_out, o_miso_pad_oe,
         o_spi_miso_in, o_spi_mosi_in}, 7'h7A);
    i_spi_mosi_oe <= 1'b0;
    cyc(3);
    chk(o_mosi_pad_oe, 1'b0);
    $display("test master done");
    i_spi_master <= 1'b0;
    i_spi_miso_oe <= 1'b1;
    far_oe <= 4'h5;
    far_val <= 4'h5;
    cyc(5);
    chk({o_sclk_pad_oe, o_spi_sclk_in, o_mosi_pad_oe, o_spi_mosi_in, o_miso_pad_oe,
         o_miso_pad_out, o_spi_miso_in}, 7'h2C);
    i_spi_miso_oe <= 1'b0;
    cyc(3);
    chk(o_miso_pad_oe, 1'b0);
    $display("test slave done");
    i_spi_master <= 1'b1;
    i_spi_select_n <= 2'h0;
    i_sw_pull_low <= 1'b1;
    i_strong_pullup_enable_n <= 1'b0;
    far_oe <= 4'h8;
    far_val <= 4'h0;
    for (int f = 0; f < 4; f++) begin
      bus(1, 5'h0C, f);
      cyc(3);
      chk({o_shared_a_pad_oe, o_shared_b_pad_oe, o_shared_b_pad_out & o_shared_b_pad_oe,
           o_sw_data_in, o_can_receive}, fn_exp[f]);
    end
    bus(1, 5'h0C, 32'h1);
    i_sw_pull_low <= 1'b0;
    i_strong_pullup_enable_n <= 1'b1;
    cyc(5);
    chk({o_shared_a_pad_out, o_shared_a_pad_oe, o_sw_data_in, o_shared_b_pad_oe,
         o_shared_b_pad_out}, 5'h03);
    $display("test shared pins done");
    bus(1, 5'h0C, 32'h0);
    i_ext_clock_pad_in <= 1'b1;
    i_counter_module_pin_in <= 5'h1F;
    i_serial1_transmit <= 1'b1;
    i_counter_module_oe <= 5'h1F;
    i_counter_module_out <= 5'h1E;
    cyc(5);
    chk({o_counter_array_ext_clock, o_serial1_receive, o_timer1_gate, o_timer1_clock,
         o_timer2_gate, o_timer2_clock, o_counter_module_in, o_counter_module_pin_oe,
         o_counter_module_pin_out}, 21'h0F8021);
    bus(1, 5'h0C, 32'h1C);
    cyc(3);
    chk({o_counter_array_ext_clock, o_serial1_receive, o_timer1_gate, o_timer1_clock,
         o_timer2_gate, o_timer2_clock, o_counter_module_in, o_counter_module_pin_oe,
         o_counter_module_pin_out}, 21'h187FFE);
    $display("test counter pins done");
    i_eth_rx_pos_pin_in <= 1'b1;
    i_eth_tx_pos <= 1'b1;
    cyc(5);
    chk({o_eth_rx_pos, o_eth_rx_pos_pin_oe}, 2'h2);
    i_eth_mdix <= 1'b1;
    cyc(5);
    chk({o_eth_rx_pos, o_eth_rx_pos_pin_oe, o_eth_rx_pos_pin_out}, 3'h3);
    $display("test crossover done");
    conclude();
  end
endmodule : pmx_pad_mux_tb

/* verif/pmx_pad_peer.sv */
/*
  Far-side model of the serial clock, data and shared single-wire pads.
  Assumes the bench says what the far devices drive and when they let go.
*/
`timescale 1ns/1ns
module pmx_pad_peer (
  input wire logic [3:0] i_dut_out,
  input wire logic [3:0] i_dut_oe,
  input wire logic [3:0] i_far_val,
  input wire logic [3:0] i_far_oe,
  output logic [3:0] o_pad
);
  // Bits are sclk, miso, mosi and shared data, each with an external pull-up.
  // A released wire rests at the pull-up, never at its last driven value.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pad[k] = i_dut_oe[k] ? i_dut_out[k] : (i_far_oe[k] ? i_far_val[k] : 1'b1);
    end
  end
endmodule : pmx_pad_peer
